// File: verilog/dcw_pkg.sv
// dcw_pkg: shared constants and types of the device configuration word block
package dcw_pkg;

  // program address space
  localparam logic [13:0] DCW_CFG_ADDR = 14'h2007;
  localparam logic [13:0] DCW_SPACE_LO = 14'h2000;
  localparam logic [13:0] DCW_SPACE_HI = 14'h3FFF;
  // erased word: every bit unprogrammed
  localparam logic [13:0] DCW_ERASED = 14'h3FFF;

  // field positions inside the configuration word
  localparam int DCW_OSC_LSB = 0;
  localparam int DCW_WDT_BIT = 3;
  localparam int DCW_POWERUP_TIMER_BIT = 4;
  localparam int DCW_MCLR_BIT = 7;
  localparam int DCW_CP_PAIRS = 4;
  localparam int DCW_CP_LSB0 = 5;
  localparam int DCW_CP_LSB1 = 8;
  localparam int DCW_CP_LSB2 = 10;
  localparam int DCW_CP_LSB3 = 12;
  localparam logic [1:0] DCW_CP_OFF = 2'h3;

  // oscillator selection codes
  localparam logic [2:0] DCW_OSC_LP = 3'h0;
  localparam logic [2:0] DCW_OSC_XT = 3'h1;
  localparam logic [2:0] DCW_OSC_HS = 3'h2;
  localparam logic [2:0] DCW_OSC_INTERNAL_RC_MODE_IO = 3'h4;
  localparam logic [2:0] DCW_OSC_INTERNAL_RC_MODE_CLK = 3'h5;
  localparam logic [2:0] DCW_OSC_EXTERNAL_RC_MODE_IO = 3'h6;
  localparam logic [2:0] DCW_OSC_EXTERNAL_RC_MODE_CLK = 3'h7;

  // timing
  localparam int DCW_CLK_HZ = 10_000_000;
  localparam int DCW_POWERUP_TIMER_MS = 72;
  localparam int DCW_POWERUP_TIMER_CYCLES = (DCW_POWERUP_TIMER_MS * (DCW_CLK_HZ / 1000));
  localparam int DCW_INTERNAL_RC_MODE_HZ = 4_000_000;
  localparam int DCW_CLOCK_OUTPUT_PIN_DIV = 4;
  localparam int DCW_CLOCK_OUTPUT_PIN_HALF = (DCW_CLK_HZ * DCW_CLOCK_OUTPUT_PIN_DIV) / (2 * DCW_INTERNAL_RC_MODE_HZ);
  localparam int DCW_OST_TICKS = 1024;
  localparam int DCW_WDT_TICKS = 256;
  localparam int DCW_TMR_W = 32;

  // pin synchroniser: bit 0 external reset (idle high), bit 1 oscillator, bit 2 watchdog rc
  localparam logic [2:0] DCW_PIN_IDLE = 3'h1;

  typedef enum logic [2:0] {
    DCW_MODE_LP,
    DCW_MODE_XT,
    DCW_MODE_HS,
    DCW_MODE_INTERNAL_RC_MODE,
    DCW_MODE_EXTERNAL_RC_MODE
  } dcw_mode_t;

  typedef enum logic [2:0] {
    DCW_ST_BOOT,
    DCW_ST_POWERUP_TIMER,
    DCW_ST_OST,
    DCW_ST_RUN,
    DCW_ST_SLEEP,
    DCW_ST_XRST
  } dcw_state_t;

  typedef struct packed {
    dcw_mode_t mode;
    logic clock_output_pin_en;
    logic wdt_en;
    logic powerup_timer_en;
    logic mclr_en;
    logic cp_valid;
    logic [1:0] cp_level;
  } dcw_opts_t;

  localparam dcw_opts_t DCW_OPTS_RST = '{mode: DCW_MODE_LP, clock_output_pin_en: 1'b0, wdt_en: 1'b0,
                                        powerup_timer_en: 1'b0, mclr_en: 1'b0, cp_valid: 1'b0, cp_level: 2'h3};

endpackage : dcw_pkg

// File: verilog/dcw_timer.sv
// dcw_timer: loadable down counter advanced by a tick enable
`timescale 1ns/1ps
module dcw_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] load,
  // status
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_busy;
  logic next_done;

  // start wins over a running count; a load of zero finishes on the first tick
  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_cnt = load;
      next_busy = 1'b1;
    end else if (busy && tick) begin
      if (cnt <= W'(1)) begin
        next_cnt = '0;
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : dcw_timer

// File: verilog/dcw_config_word.sv
// dcw_config_word: configuration word store, option decode and reset/sleep sequencer
// Operation
// - configuration bits read 0 when programmed, 1 when left erased
// - word lives at 2007h in space 2000h-3FFFh, reachable only in programming mode
// - three-bit field selects one of seven oscillator modes
// - only the fuse disables the watchdog; it runs from its own rc clock
// - power-up timer holds reset 72 ms after power-up only, when enabled
// - start-up timer holds reset until the crystal oscillator is stable
// - sleep ends on external reset, watchdog wake-up or enabled interrupt
// - internal rc gives 4 MHz; rc modes may drive a clock output pin
`timescale 1ns/1ps
module dcw_config_word #(
  parameter int POWERUP_TIMER_CYCLES = dcw_pkg::DCW_POWERUP_TIMER_CYCLES,
  parameter int OST_TICKS = dcw_pkg::DCW_OST_TICKS,
  parameter int WDT_TICKS = dcw_pkg::DCW_WDT_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // programming port
  input wire logic prog_mode,
  input wire logic [13:0] prog_addr,
  input wire logic [13:0] prog_wdata,
  input wire logic prog_write,
  input wire logic prog_read,
  output logic [13:0] prog_rdata,
  output logic prog_rvalid,
  // pins
  input wire logic mclr_pin_n,
  input wire logic osc_pin,
  input wire logic wdt_rc_pin,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  // core side
  input wire logic sleep_req,
  input wire logic wdt_clear,
  input wire logic irq_pending,
  output logic device_reset_n,
  output logic in_sleep,
  output logic wake_event,
  output logic wdt_reset,
  output dcw_pkg::dcw_opts_t options,
  output logic cp_mismatch
);

  localparam int TW = dcw_pkg::DCW_TMR_W;
  localparam int CLOCK_OUTPUT_PIN_GAP = dcw_pkg::DCW_CLOCK_OUTPUT_PIN_HALF;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] s1, s2, s3, filt, filt_d;
  logic [2:0] next_filt;

  // a level counts only once the second and third stages agree
  generate
    for (genvar i = 0; i < 3; i++) begin : g_pin
      assign next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= dcw_pkg::DCW_PIN_IDLE;
      s2 <= dcw_pkg::DCW_PIN_IDLE;
      s3 <= dcw_pkg::DCW_PIN_IDLE;
      filt <= dcw_pkg::DCW_PIN_IDLE;
      filt_d <= dcw_pkg::DCW_PIN_IDLE;
    end else begin
      s1 <= {wdt_rc_pin, osc_pin, mclr_pin_n};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      filt_d <= filt;
    end
  end

  logic mclr_low, osc_tick, wdt_tick;
  assign osc_tick = filt[1] & ~filt_d[1];
  assign wdt_tick = filt[2] & ~filt_d[2];

  ////////////////////////////////////////////////////////////////////////////
  // configuration word store and programming port
  // the store starts blank at power of the model and is non-volatile from then on
  logic [13:0] cfg_word = dcw_pkg::DCW_ERASED;
  logic [13:0] next_cfg_word;
  logic [13:0] next_rdata;
  logic next_rvalid;
  logic cfg_hit, space_hit;

  assign cfg_hit = prog_mode && (prog_addr == dcw_pkg::DCW_CFG_ADDR);
  assign space_hit = prog_mode && (prog_addr >= dcw_pkg::DCW_SPACE_LO) && (prog_addr <= dcw_pkg::DCW_SPACE_HI);

  always_comb begin
    next_cfg_word = cfg_word;
    next_rdata = prog_rdata;
    next_rvalid = 1'b0;
    // programming can only turn erased ones into zeros
    if (cfg_hit && prog_write) begin
      next_cfg_word = cfg_word & prog_wdata;
    end
    if (space_hit && prog_read) begin
      next_rvalid = 1'b1;
      next_rdata = cfg_hit ? cfg_word : dcw_pkg::DCW_ERASED;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_rdata <= '0;
      prog_rvalid <= 1'b0;
    end else begin
      prog_rdata <= next_rdata;
      prog_rvalid <= next_rvalid;
    end
  end

  // no reset: a programmed word must survive rst_n so that the next boot decodes it
  always_ff @(posedge clk_sys) begin
    cfg_word <= next_cfg_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // option decode
  dcw_pkg::dcw_opts_t dec, next_options;
  logic [1:0] cp_pair [dcw_pkg::DCW_CP_PAIRS];
  logic cp_agree, crystal;

  assign cp_pair[0] = cfg_word[dcw_pkg::DCW_CP_LSB0 +: 2];
  assign cp_pair[1] = cfg_word[dcw_pkg::DCW_CP_LSB1 +: 2];
  assign cp_pair[2] = cfg_word[dcw_pkg::DCW_CP_LSB2 +: 2];
  assign cp_pair[3] = cfg_word[dcw_pkg::DCW_CP_LSB3 +: 2];
  assign cp_agree = (cp_pair[0] == cp_pair[1]) && (cp_pair[0] == cp_pair[2]) && (cp_pair[0] == cp_pair[3]);

  always_comb begin
    dec = dcw_pkg::DCW_OPTS_RST;
    case (cfg_word[dcw_pkg::DCW_OSC_LSB +: 3])
      dcw_pkg::DCW_OSC_LP: dec.mode = dcw_pkg::DCW_MODE_LP;
      dcw_pkg::DCW_OSC_HS: dec.mode = dcw_pkg::DCW_MODE_HS;
      dcw_pkg::DCW_OSC_INTERNAL_RC_MODE_IO: dec.mode = dcw_pkg::DCW_MODE_INTERNAL_RC_MODE;
      dcw_pkg::DCW_OSC_INTERNAL_RC_MODE_CLK: begin
        dec.mode = dcw_pkg::DCW_MODE_INTERNAL_RC_MODE;
        dec.clock_output_pin_en = 1'b1;
      end
      dcw_pkg::DCW_OSC_EXTERNAL_RC_MODE_IO: dec.mode = dcw_pkg::DCW_MODE_EXTERNAL_RC_MODE;
      dcw_pkg::DCW_OSC_EXTERNAL_RC_MODE_CLK: begin
        dec.mode = dcw_pkg::DCW_MODE_EXTERNAL_RC_MODE;
        dec.clock_output_pin_en = 1'b1;
      end
      default: dec.mode = dcw_pkg::DCW_MODE_XT;
    endcase
    dec.wdt_en = cfg_word[dcw_pkg::DCW_WDT_BIT];
    dec.powerup_timer_en = ~cfg_word[dcw_pkg::DCW_POWERUP_TIMER_BIT];
    dec.mclr_en = cfg_word[dcw_pkg::DCW_MCLR_BIT];
    // a split code is treated as unprotected rather than guessing a level
    dec.cp_valid = cp_agree && (cp_pair[0] != dcw_pkg::DCW_CP_OFF);
    dec.cp_level = cp_agree ? cp_pair[0] : dcw_pkg::DCW_CP_OFF;
  end

  assign crystal = (options.mode == dcw_pkg::DCW_MODE_LP) || (options.mode == dcw_pkg::DCW_MODE_XT) ||
                   (options.mode == dcw_pkg::DCW_MODE_HS);
  assign mclr_low = options.mclr_en && !filt[0];

  ////////////////////////////////////////////////////////////////////////////
  // timers
  logic pt_start, pt_busy, pt_done;
  logic ost_start, ost_busy, ost_done;
  logic wd_start, wd_busy, wd_done, wd_live;

  dcw_timer #(.W(TW)) u_powerup_timer (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(pt_start), .tick(1'b1),
    .load(TW'(POWERUP_TIMER_CYCLES)), .busy(pt_busy), .done(pt_done)
  );
  dcw_timer #(.W(TW)) u_ost (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(ost_start), .tick(osc_tick),
    .load(TW'(OST_TICKS)), .busy(ost_busy), .done(ost_done)
  );
  // watchdog counts edges of its own rc pin, never the system clock rate
  dcw_timer #(.W(TW)) u_wdt (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(wd_start), .tick(wdt_tick),
    .load(TW'(WDT_TICKS)), .busy(wd_busy), .done(wd_done)
  );

  dcw_pkg::dcw_state_t state, next_state;
  assign wd_live = options.wdt_en && ((state == dcw_pkg::DCW_ST_RUN) || (state == dcw_pkg::DCW_ST_SLEEP));
  assign wd_start = wd_live && (wdt_clear || !wd_busy) && !wd_done;

  ////////////////////////////////////////////////////////////////////////////
  // reset and sleep sequencer
  logic next_reset_n, next_sleep, next_wake, next_wdt_reset;

  always_comb begin
    next_state = state;
    next_options = options;
    next_wake = 1'b0;
    next_wdt_reset = 1'b0;
    pt_start = 1'b0;
    ost_start = 1'b0;
    case (state)
      dcw_pkg::DCW_ST_BOOT: begin
        next_options = dec;
        if (dec.powerup_timer_en) begin
          pt_start = 1'b1;
          next_state = dcw_pkg::DCW_ST_POWERUP_TIMER;
        end else begin
          next_state = dcw_pkg::DCW_ST_XRST;
        end
      end
      dcw_pkg::DCW_ST_POWERUP_TIMER: begin
        if (pt_done) begin
          next_state = dcw_pkg::DCW_ST_XRST;
        end
      end
      dcw_pkg::DCW_ST_XRST: begin
        if (!mclr_low) begin
          ost_start = crystal;
          next_state = crystal ? dcw_pkg::DCW_ST_OST : dcw_pkg::DCW_ST_RUN;
        end
      end
      dcw_pkg::DCW_ST_OST: begin
        if (mclr_low) begin
          next_state = dcw_pkg::DCW_ST_XRST;
        end else if (ost_done) begin
          next_state = dcw_pkg::DCW_ST_RUN;
        end
      end
      dcw_pkg::DCW_ST_RUN: begin
        if (mclr_low) begin
          next_state = dcw_pkg::DCW_ST_XRST;
        end else if (wd_done) begin
          next_wdt_reset = 1'b1;
          next_state = dcw_pkg::DCW_ST_XRST;
        end else if (sleep_req) begin
          next_state = dcw_pkg::DCW_ST_SLEEP;
        end
      end
      dcw_pkg::DCW_ST_SLEEP: begin
        if (mclr_low) begin
          next_wake = 1'b1;
          next_state = dcw_pkg::DCW_ST_XRST;
        end else if (wd_done || irq_pending) begin
          next_wake = 1'b1;
          ost_start = crystal;
          next_state = crystal ? dcw_pkg::DCW_ST_OST : dcw_pkg::DCW_ST_RUN;
        end
      end
      default: next_state = dcw_pkg::DCW_ST_BOOT;
    endcase
    next_reset_n = (next_state == dcw_pkg::DCW_ST_RUN) || (next_state == dcw_pkg::DCW_ST_SLEEP);
    next_sleep = (next_state == dcw_pkg::DCW_ST_SLEEP);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= dcw_pkg::DCW_ST_BOOT;
      options <= dcw_pkg::DCW_OPTS_RST;
      device_reset_n <= 1'b0;
      in_sleep <= 1'b0;
      wake_event <= 1'b0;
      wdt_reset <= 1'b0;
      cp_mismatch <= 1'b0;
    end else begin
      state <= next_state;
      options <= next_options;
      device_reset_n <= next_reset_n;
      in_sleep <= next_sleep;
      wake_event <= next_wake;
      wdt_reset <= next_wdt_reset;
      cp_mismatch <= !cp_agree;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output: instruction rate, a quarter of the 4 MHz internal rc
  logic [7:0] div_cnt, next_div_cnt;
  logic next_clk_o;

  // exact only in internal rc mode; in external rc mode the pin shows the nominal rate
  always_comb begin
    next_div_cnt = div_cnt;
    next_clk_o = clock_output_pin_o;
    if (!options.clock_output_pin_en) begin
      next_div_cnt = '0;
      next_clk_o = 1'b0;
    end else if (div_cnt == 8'(CLOCK_OUTPUT_PIN_GAP - 1)) begin
      next_div_cnt = '0;
      next_clk_o = !clock_output_pin_o;
    end else begin
      next_div_cnt = div_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      clock_output_pin_o <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clock_output_pin_o <= next_clk_o;
      clock_output_pin_oe <= options.clock_output_pin_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sleep_irq;
    (state == dcw_pkg::DCW_ST_SLEEP) && irq_pending && !mclr_low;
  endsequence
  sequence s_leave_sleep;
    (state != dcw_pkg::DCW_ST_SLEEP) && wake_event;
  endsequence

  a_program_clears: assert property (cfg_hit && prog_write |=> (cfg_word & ~$past(prog_wdata)) == 14'h0000)
    else $error("programmed bit reads as one");
  a_word_only_addr: assert property ($changed(cfg_word) |-> $past(cfg_hit && prog_write))
    else $error("word changed outside programming access");
  a_read_in_space: assert property (prog_rvalid |-> $past(space_hit && prog_read))
    else $error("read answered outside programming space");
  a_osc_rc_decode: assert property ($past(state == dcw_pkg::DCW_ST_BOOT) && (state != dcw_pkg::DCW_ST_BOOT)
    && $past(cfg_word[2:0]) == dcw_pkg::DCW_OSC_INTERNAL_RC_MODE_CLK
    |-> options.mode == dcw_pkg::DCW_MODE_INTERNAL_RC_MODE && options.clock_output_pin_en)
    else $error("oscillator field misdecoded");
  a_wdt_fuse_only: assert property (wd_busy |-> options.wdt_en)
    else $error("watchdog runs with fuse cleared");
  a_powerup_timer_powerup: assert property ((state == dcw_pkg::DCW_ST_POWERUP_TIMER) && !$past(state == dcw_pkg::DCW_ST_POWERUP_TIMER)
    |-> $past(state == dcw_pkg::DCW_ST_BOOT) && !device_reset_n)
    else $error("power-up delay entered from a later reset");
  a_ost_hold: assert property ((state == dcw_pkg::DCW_ST_OST) |-> !device_reset_n && !in_sleep)
    else $error("released during start-up wait");
  a_sleep_wake: assert property (s_sleep_irq |=> s_leave_sleep)
    else $error("interrupt did not end sleep");
  a_clock_output_pin_rate: assert property (clock_output_pin_oe && options.clock_output_pin_en && $changed(clock_output_pin_o)
    |-> ##CLOCK_OUTPUT_PIN_GAP $changed(clock_output_pin_o))
    else $error("clock output period wrong");
  a_layout_bits: assert property ($past(state == dcw_pkg::DCW_ST_BOOT) && (state != dcw_pkg::DCW_ST_BOOT)
    |-> options.mclr_en == $past(cfg_word[7])
    && options.powerup_timer_en == !$past(cfg_word[4]) && options.wdt_en == $past(cfg_word[3]))
    else $error("option bits taken from wrong positions");
  a_cp_agree: assert property (!cp_agree |-> !dec.cp_valid && (dec.cp_level == dcw_pkg::DCW_CP_OFF))
    else $error("protection applied to split code");

endmodule : dcw_config_word

// File: verif/dcw_programmer_model.sv
// dcw_programmer_model: external programmer driving the configuration programming port
`timescale 1ns/1ps
module dcw_programmer_model (
  // clock
  input wire logic clk_sys,
  // programming port
  output logic prog_mode,
  output logic [13:0] prog_addr,
  output logic [13:0] prog_wdata,
  output logic prog_write,
  output logic prog_read,
  // read answer
  input wire logic [13:0] prog_rdata,
  input wire logic prog_rvalid
);
  initial begin
    prog_mode = 1'b0;
    prog_addr = 14'h0000;
    prog_wdata = 14'h1555;
    prog_write = 1'b0;
    prog_read = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access: request held over one sampling edge; the answer stands in the cycle after that edge
  task automatic access(input logic mode, input logic [13:0] addr, input logic [13:0] data,
                        input logic rd, output logic got, output logic [13:0] rdata);
    @(posedge clk_sys);
    #10;
    prog_mode = mode;
    prog_addr = addr;
    prog_wdata = data;
    prog_write = ~rd;
    prog_read = rd;
    @(posedge clk_sys);
    #10;
    got = prog_rvalid;
    rdata = prog_rdata;
    // strobes drop to zero and address and data are inverted, so a stale sample cannot pass
    prog_mode = 1'b0;
    prog_write = 1'b0;
    prog_read = 1'b0;
    prog_addr = ~addr;
    prog_wdata = ~data;
  endtask : access
endmodule : dcw_programmer_model

// File: verif/device_configuration_word_tb_top.sv
// device_configuration_word_tb_top: self-checking bench of the configuration word block
`timescale 1ns/1ps
module device_configuration_word_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n, mclr_pin_n, osc_pin, wdt_rc_pin, sleep_req, wdt_clear, irq_pending;
  logic osc_run, wdt_run, got;
  logic prog_mode, prog_write, prog_read, prog_rvalid;
  logic [13:0] prog_addr, prog_wdata, prog_rdata, rd;
  logic clock_output_pin_o, clock_output_pin_oe, device_reset_n, in_sleep, wake_event, wdt_reset;
  logic cp_mismatch;
  dcw_pkg::dcw_opts_t options;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;

  always #50 clk_sys = ~clk_sys;
  // half periods never meet a rising clock edge and span at least two samples of the pin filter
  always #260 if (osc_run) osc_pin = ~osc_pin;
  always #740 if (wdt_run) wdt_rc_pin = ~wdt_rc_pin;

  // short counts keep the run brief; expectations below follow these values
  dcw_config_word #(.POWERUP_TIMER_CYCLES(60), .OST_TICKS(4), .WDT_TICKS(4)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .prog_mode(prog_mode), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_write(prog_write), .prog_read(prog_read), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .mclr_pin_n(mclr_pin_n), .osc_pin(osc_pin), .wdt_rc_pin(wdt_rc_pin),
    .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe),
    .sleep_req(sleep_req), .wdt_clear(wdt_clear), .irq_pending(irq_pending),
    .device_reset_n(device_reset_n), .in_sleep(in_sleep), .wake_event(wake_event),
    .wdt_reset(wdt_reset), .options(options), .cp_mismatch(cp_mismatch));

  dcw_programmer_model pr (
    .clk_sys(clk_sys), .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_write(prog_write), .prog_read(prog_read), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys);
    #10;
  endtask : step

  task automatic power_on();
    rst_n = 1'b0;
    repeat (8) step();
    rst_n = 1'b1;
  endtask : power_on

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = device_reset_n;
      1: pick = wdt_reset;
      default: pick = wake_event;
    endcase
  endfunction : pick

  // bounded wait for one of the sequencer outputs to be high
  task automatic wait_sig(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (pick(sel) !== 1'b1 && cnt < lim) begin
      step();
      cnt++;
    end
  endtask : wait_sig

  task automatic clock_output_pin_half(output int cnt);
    logic v;
    cnt = 0;
    v = clock_output_pin_o;
    while (clock_output_pin_o === v && cnt < 20) begin
      step();
      cnt++;
    end
    v = clock_output_pin_o;
    cnt = 0;
    while (clock_output_pin_o === v && cnt < 20) begin
      step();
      cnt++;
    end
  endtask : clock_output_pin_half

  task automatic sleep_now();
    sleep_req = 1'b1;
    step();
    sleep_req = 1'b0;
    step();
    chk(in_sleep, 1'b1, "sleep entered");
  endtask : sleep_now

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, osc_pin, wdt_rc_pin, sleep_req, wdt_clear, irq_pending, osc_run, wdt_run} = 8'h00;
    mclr_pin_n = 1'b1;
    power_on();
    // erased word: external rc with clock output, watchdog and reset pin on
    wait_sig(0, 10, n);
    chk(device_reset_n, 1'b1, "run without timers");
    chk({6'h0, options}, {6'h0, dcw_pkg::DCW_MODE_EXTERNAL_RC_MODE, 5'b11010, 2'h3}, "erased options");
    chk(clock_output_pin_oe, 1'b1, "clock out driven");
    clock_output_pin_half(n);
    chk(n[15:0], 16'h0005, "clock out half period");
    pr.access(1'b1, dcw_pkg::DCW_CFG_ADDR, 14'h0000, 1'b1, got, rd);
    chk({got, rd}, {1'b1, 14'h3FFF}, "erased read");
    pr.access(1'b1, 14'h2000, 14'h0000, 1'b1, got, rd);
    chk({got, rd}, {1'b1, 14'h3FFF}, "space low read");
    pr.access(1'b1, 14'h1FFF, 14'h0000, 1'b1, got, rd);
    chk(got, 1'b0, "read below space");
    pr.access(1'b0, dcw_pkg::DCW_CFG_ADDR, 14'h0000, 1'b1, got, rd);
    chk(got, 1'b0, "read outside programming");
    wdt_run = 1'b1;
    wait_sig(1, 150, n);
    chk(wdt_reset, 1'b1, "watchdog timeout");
    wdt_run = 1'b0;
    wait_sig(0, 20, n);
    sleep_now();
    irq_pending = 1'b1;
    wait_sig(2, 10, n);
    chk(wake_event, 1'b1, "interrupt wake");
    irq_pending = 1'b0;
    step();
    chk(in_sleep, 1'b0, "awake");
    sleep_now();
    mclr_pin_n = 1'b0;
    repeat (6) step();
    chk({device_reset_n, in_sleep}, 2'b00, "reset pin wake");
    mclr_pin_n = 1'b1;
    wait_sig(0, 12, n);
    chk(device_reset_n, 1'b1, "back to run");
    $display("test erased word done");

    // split protection pairs and internal rc with clock output; ignored writes first
    pr.access(1'b0, dcw_pkg::DCW_CFG_ADDR, 14'h0000, 1'b0, got, rd);
    pr.access(1'b1, 14'h2006, 14'h0000, 1'b0, got, rd);
    pr.access(1'b1, dcw_pkg::DCW_CFG_ADDR, 14'h3F9D, 1'b0, got, rd); // programmer breaks pair rule here
    pr.access(1'b1, dcw_pkg::DCW_CFG_ADDR, 14'h0000, 1'b1, got, rd);
    chk({got, rd}, {1'b1, 14'h3F9D}, "programmed read");
    power_on();
    // options land on the first edge after release, the pin enable one edge later
    repeat (2) step();
    chk({6'h0, options}, {6'h0, dcw_pkg::DCW_MODE_INTERNAL_RC_MODE, 5'b11010, 2'h3}, "rc options");
    chk({cp_mismatch, clock_output_pin_oe}, 2'b11, "split pairs");
    // clearing faster than the timeout keeps the watchdog quiet
    wdt_run = 1'b1;
    n = 0;
    repeat (6) begin
      wdt_clear = 1'b1;
      step();
      wdt_clear = 1'b0;
      repeat (19) begin
        step();
        if (wdt_reset === 1'b1) n++;
      end
    end
    chk(n[15:0], 16'h0000, "cleared watchdog quiet");
    sleep_now();
    wait_sig(2, 150, n);
    chk({wake_event, device_reset_n}, 2'b11, "watchdog wake");
    wait_sig(1, 150, n);
    chk(wdt_reset, 1'b1, "uncleared watchdog fires");
    wdt_run = 1'b0;
    wait_sig(0, 20, n);
    $display("test split protection done");

    // crystal mode, power-up timer on, watchdog off, all pairs agree
    pr.access(1'b1, dcw_pkg::DCW_CFG_ADDR, 14'h0081, 1'b0, got, rd);
    pr.access(1'b1, dcw_pkg::DCW_CFG_ADDR, 14'h0000, 1'b1, got, rd);
    chk({got, rd}, {1'b1, 14'h0081}, "cleared bits read");
    osc_run = 1'b1;
    power_on();
    repeat (50) step();
    chk(device_reset_n, 1'b0, "held by power-up timer");
    chk({6'h0, options}, {6'h0, dcw_pkg::DCW_MODE_XT, 5'b00111, 2'h0}, "crystal options");
    chk({cp_mismatch, clock_output_pin_oe}, 2'b00, "pairs agree, pin free");
    wait_sig(0, 60, n);
    chk(device_reset_n, 1'b1, "released after timers");
    osc_run = 1'b0;
    mclr_pin_n = 1'b0;
    repeat (6) step();
    chk(device_reset_n, 1'b0, "reset pin");
    mclr_pin_n = 1'b1;
    repeat (30) step();
    chk(device_reset_n, 1'b0, "waits for stable oscillator");
    osc_run = 1'b1;
    wait_sig(0, 40, n);
    chk(device_reset_n, 1'b1, "no power-up delay after pin reset");
    wdt_run = 1'b1;
    n = 0;
    repeat (120) begin
      step();
      if (wdt_reset === 1'b1) n++;
    end
    chk(n[15:0], 16'h0000, "watchdog fused off");
    $display("test crystal word done");
    conclude();
  end

  initial begin
    #2_000_000;
    n_mismatch++;
    $display("wrong value at %0t: run did not finish", $time);
    conclude();
  end
endmodule : device_configuration_word_tb_top
